/* verilog/port_defines.svh */
// register map, field positions and timing figures for the host port controller
`ifndef PORT_DEFINES_SVH
`define PORT_DEFINES_SVH

// register offsets (byte addresses, one word each)
`define CTRL_OFS         4'h0
`define STATUS_OFS       4'h4
`define FRAME_OFS        4'h8

// control register fields
`define CTRL_START_BIT   0
`define CTRL_FS_BIT      1
`define CTRL_SUSP_BIT    2
`define CTRL_RESUME_BIT  3
`define CTRL_TEST_LSB    4
`define CTRL_TEST_MSB    5

// status register fields
`define STAT_STATE_LSB   0
`define STAT_STATE_MSB   10
`define STAT_HS_BIT      16
`define STAT_PAIRS_LSB   17
`define STAT_PAIRS_MSB   18

// reset values and counter increments
`define WORD_ZERO        32'h0000_0000
`define FRAME_ZERO       11'h000
`define PAIRS_ZERO       2'h0
`define PAIRS_ONE        2'h1
`define FRAME_ONE        11'h001

// timing figures in their own units
`define CLK_PERIOD_NS    5
`define RESP_MAX_US      100
`define CHIRP_MIN_US     40
`define CHIRP_MAX_US     60
`define SOF1_MIN_US      100
`define SOF1_MAX_US      500
`define HS_FRAME_US      125
`define FS_FRAME_MS      1
`define RESUME_SOF_MS    3
`define CHIRP_PAIRS      3

`endif

/* verilog/port_pkg.sv */
// types used by the host port controller: sequencer states and test modes
package port_pkg;

    // port sequencer states, one-hot
    typedef enum logic [10:0] {
        ST_IDLE      = 11'h001,
        ST_RESET     = 11'h002,
        ST_DEV_CHIRP = 11'h004,
        ST_RESP      = 11'h008,
        ST_CHIRP_K   = 11'h010,
        ST_CHIRP_J   = 11'h020,
        ST_SOF_WAIT  = 11'h040,
        ST_RUN       = 11'h080,
        ST_SUSPEND   = 11'h100,
        ST_RESUME    = 11'h200,
        ST_TEST      = 11'h400
    } port_state_t;

    // electrical test mode selection
    typedef enum logic [1:0] {
        TM_OFF     = 2'h0,
        TM_J       = 2'h1,
        TM_K       = 2'h2,
        TM_SE0_NAK = 2'h3
    } test_mode_t;

endpackage : port_pkg

/* verilog/timer_if.sv */
// load/expire handshake between the port sequencer and its interval timer
interface timer_if #(parameter int TW = 20);
    logic          load;
    logic [TW-1:0] value;
    logic          expired;

    modport ctl (output load, output value, input expired);
    modport tmr (input load, input value, output expired);
endinterface : timer_if

/* verilog/tick_timer.sv */
// down-counting interval timer: expires in the value-th cycle after a load
module tick_timer #(
    parameter int TW = 20
) (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    timer_if.tmr      tif
);
    logic [TW-1:0] cnt_q;

    // reload wins over counting; holds at zero when idle
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= '0;
        end else if (tif.load) begin
            cnt_q <= tif.value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - TW'(1);
        end
    end

    assign tif.expired = (cnt_q == TW'(1));
endmodule : tick_timer

/* verilog/usb_port_ctrl.sv */
// downstream host port: chirp handshake, frame markers, suspend/resume, test modes
// How it works
// - host chirps begin within 100 us after the device chirp K ends.
// - every host chirp K or J lasts 40 to 60 us.
// - host sends at least three chirp K/J pairs.
// - first frame marker 100 to 500 us after the last chirp.
// - high-speed frame marker every 125 us while running.
// - suspend stops frame markers entirely.
// - frame markers restart within 3 ms after resume ends.
// - firmware selects Test_J, Test_K or Test_SE0_NAK modes.
// - Test_SE0_NAK runs high speed with both lines released.
// - Test_J drives D+ high, D- low until exited.
// - Test_K drives D- high, D+ low until exited.
// - full-speed operation emits a frame marker every frame.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`include "port_defines.svh"

module usb_port_ctrl
    import port_pkg::*;
#(
    parameter int TW             = 20,
    parameter int RESP_MAX_CYC   = (`RESP_MAX_US * 1000) / `CLK_PERIOD_NS,
    parameter int CHIRP_MIN_CYC  = (`CHIRP_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int CHIRP_MAX_CYC  = (`CHIRP_MAX_US * 1000) / `CLK_PERIOD_NS,
    parameter int SOF1_MIN_CYC   = (`SOF1_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int SOF1_MAX_CYC   = (`SOF1_MAX_US * 1000) / `CLK_PERIOD_NS,
    parameter int HS_FRAME_CYC   = (`HS_FRAME_US * 1000) / `CLK_PERIOD_NS,
    parameter int FS_FRAME_CYC   = (`FS_FRAME_MS * 1000000) / `CLK_PERIOD_NS,
    parameter int RESUME_MAX_CYC = (`RESUME_SOF_MS * 1000000) / `CLK_PERIOD_NS
) (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic        dp_in,
    input  wire logic        dm_in,
    output logic             dp_out,
    output logic             dm_out,
    output logic             dp_oe_n_out,
    output logic             dm_oe_n_out,
    output logic             hs_mode_out,
    output logic             sof_out,
    input  wire logic        in_token_in,
    output logic             nak_out
);
    // working intervals sit inside the allowed windows
    localparam int RESP_CYC  = RESP_MAX_CYC / 2;
    localparam int CHIRP_CYC = (CHIRP_MIN_CYC + CHIRP_MAX_CYC) / 2;
    localparam int SOF1_CYC  = (SOF1_MIN_CYC + SOF1_MAX_CYC) / 2;

    port_state_t state_q, state_d;
    test_mode_t  test_q;
    logic        fs_q, susp_q, resume_q, start_q, hs_q;
    logic [1:0]  pairs_q;
    logic [10:0] frame_q;
    logic        sof_d;
    logic        dev_k;

    timer_if #(.TW(TW)) tif ();

    tick_timer #(.TW(TW)) u_timer (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .tif        (tif)
    );

    // device chirp K: D- high, D+ low while the host leaves the lines alone
    assign dev_k = dm_in & ~dp_in;

    // control register writes; start is a one-cycle pulse
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_q  <= 1'b0;
            fs_q     <= 1'b0;
            susp_q   <= 1'b0;
            resume_q <= 1'b0;
            test_q   <= TM_OFF;
        end else if (wr_in && addr_in == `CTRL_OFS) begin
            start_q  <= wdata_in[`CTRL_START_BIT];
            fs_q     <= wdata_in[`CTRL_FS_BIT];
            susp_q   <= wdata_in[`CTRL_SUSP_BIT];
            resume_q <= wdata_in[`CTRL_RESUME_BIT];
            test_q   <= test_mode_t'(wdata_in[`CTRL_TEST_MSB:`CTRL_TEST_LSB]);
        end else begin
            start_q  <= 1'b0;
        end
    end

    // sequencer next state; a test mode overrides everything
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_q) begin
                    state_d = fs_q ? ST_SOF_WAIT : ST_RESET;
                end
            end
            ST_RESET: begin
                if (dev_k) begin
                    state_d = ST_DEV_CHIRP;
                end
            end
            ST_DEV_CHIRP: begin
                if (!dev_k) begin
                    state_d = ST_RESP;
                end
            end
            ST_RESP: begin
                if (tif.expired) begin
                    state_d = ST_CHIRP_K;
                end
            end
            ST_CHIRP_K: begin
                if (tif.expired) begin
                    state_d = ST_CHIRP_J;
                end
            end
            ST_CHIRP_J: begin
                if (tif.expired) begin
                    // keep alternating until enough pairs went out
                    state_d = (pairs_q == 2'(`CHIRP_PAIRS - 1)) ? ST_SOF_WAIT
                                                                : ST_CHIRP_K;
                end
            end
            ST_SOF_WAIT: begin
                if (tif.expired) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (susp_q) begin
                    state_d = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                // firmware drops suspend before raising resume
                if (!susp_q && resume_q) begin
                    state_d = ST_RESUME;
                end
            end
            ST_RESUME: begin
                if (!resume_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_TEST: begin
                if (test_q == TM_OFF) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (test_q != TM_OFF) begin
            state_d = ST_TEST;
        end
    end

    // frame marker: first one closes the wait, then one per period
    assign sof_d = tif.expired && test_q == TM_OFF
                   && (state_q == ST_SOF_WAIT || (state_q == ST_RUN && !susp_q));

    // timer reload on every state change and on every frame boundary
    always_comb begin
        tif.load  = (state_d != state_q) || sof_d;
        tif.value = TW'(1);
        unique case (state_d)
            ST_RESP:     tif.value = TW'(RESP_CYC);
            ST_CHIRP_K:  tif.value = TW'(CHIRP_CYC);
            ST_CHIRP_J:  tif.value = TW'(CHIRP_CYC);
            ST_SOF_WAIT: tif.value = TW'(SOF1_CYC);
            ST_RUN:      tif.value = hs_q ? TW'(HS_FRAME_CYC) : TW'(FS_FRAME_CYC);
            default:     tif.value = TW'(1);
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // speed latched at port start; chirp pair counter
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hs_q    <= 1'b0;
            pairs_q <= `PAIRS_ZERO;
        end else begin
            if (state_q == ST_IDLE && start_q) begin
                hs_q <= ~fs_q;
            end
            if (state_d == ST_RESP) begin
                pairs_q <= `PAIRS_ZERO;
            end else if (state_q == ST_CHIRP_J && tif.expired) begin
                pairs_q <= pairs_q + `PAIRS_ONE;
            end
        end
    end

    // frame marker request and frame number
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sof_out <= 1'b0;
            frame_q <= `FRAME_ZERO;
        end else begin
            sof_out <= sof_d;
            if (sof_d) begin
                frame_q <= frame_q + `FRAME_ONE;
            end
        end
    end

    // line drivers; oe_n low means the port drives that line
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dp_out      <= 1'b0;
            dm_out      <= 1'b0;
            dp_oe_n_out <= 1'b1;
            dm_oe_n_out <= 1'b1;
            hs_mode_out <= 1'b0;
        end else begin
            dp_out      <= 1'b0;
            dm_out      <= 1'b0;
            dp_oe_n_out <= 1'b1;
            dm_oe_n_out <= 1'b1;
            hs_mode_out <= hs_q && (state_q == ST_SOF_WAIT || state_q == ST_RUN);
            if (state_q == ST_CHIRP_K || state_q == ST_RESUME) begin
                dm_out      <= 1'b1;
                dp_oe_n_out <= 1'b0;
                dm_oe_n_out <= 1'b0;
            end else if (state_q == ST_CHIRP_J) begin
                dp_out      <= 1'b1;
                dp_oe_n_out <= 1'b0;
                dm_oe_n_out <= 1'b0;
            end else if (state_q == ST_TEST) begin
                hs_mode_out <= 1'b1;
                if (test_q == TM_J) begin
                    dp_out      <= 1'b1;
                    dp_oe_n_out <= 1'b0;
                    dm_oe_n_out <= 1'b0;
                end else if (test_q == TM_K) begin
                    dm_out      <= 1'b1;
                    dp_oe_n_out <= 1'b0;
                    dm_oe_n_out <= 1'b0;
                end
            end
        end
    end

    // token answer is only a request; the packet engine forms the NAK
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            nak_out <= 1'b0;
        end else begin
            nak_out <= in_token_in && state_q == ST_TEST && test_q == TM_SE0_NAK;
        end
    end

    // register reads: data valid for one cycle, zero otherwise or when unmapped
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= `WORD_ZERO;
        end else begin
            rdata_out <= `WORD_ZERO;
            if (rd_in) begin
                unique case (addr_in)
                    `CTRL_OFS: begin
                        rdata_out[`CTRL_FS_BIT]     <= fs_q;
                        rdata_out[`CTRL_SUSP_BIT]   <= susp_q;
                        rdata_out[`CTRL_RESUME_BIT] <= resume_q;
                        rdata_out[`CTRL_TEST_MSB:`CTRL_TEST_LSB] <= test_q;
                    end
                    `STATUS_OFS: begin
                        rdata_out[`STAT_STATE_MSB:`STAT_STATE_LSB] <= state_q;
                        rdata_out[`STAT_HS_BIT] <= hs_q;
                        rdata_out[`STAT_PAIRS_MSB:`STAT_PAIRS_LSB] <= pairs_q;
                    end
                    `FRAME_OFS: begin
                        rdata_out[10:0] <= frame_q;
                    end
                    default: begin
                        rdata_out <= `WORD_ZERO;
                    end
                endcase
            end
        end
    end

    // helper counters for the checks below: dwell in state, gap between markers
    int  dwell_q;
    int  gap_q;
    int  res_q;
    logic gap_ok_q;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dwell_q  <= 0;
            gap_q    <= 0;
            gap_ok_q <= 1'b0;
            res_q    <= 0;
        end else begin
            dwell_q  <= (state_d != state_q) ? 0 : dwell_q + 1;
            gap_q    <= sof_d ? 0 : gap_q + 1;
            gap_ok_q <= (state_q == ST_RUN && state_d == ST_RUN) ? (gap_ok_q | sof_d) : 1'b0;
            if (state_q == ST_RESUME && state_d == ST_RUN) begin
                res_q <= 1;
            end else if (sof_d || state_d != ST_RUN) begin
                res_q <= 0;
            end else if (res_q != 0) begin
                res_q <= res_q + 1;
            end
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    resp_time_a: assert property (
        state_q == ST_RESP |-> dwell_q < RESP_MAX_CYC
    ) else $error("host chirp response too late");

    resp_next_a: assert property (
        state_q == ST_RESP && state_d != ST_RESP && test_q == TM_OFF |=> state_q == ST_CHIRP_K
    ) else $error("response wait did not lead to chirp K");

    chirp_len_a: assert property (
        (state_q == ST_CHIRP_K || state_q == ST_CHIRP_J) && state_d != state_q
            && state_d != ST_TEST
        |-> dwell_q + 1 >= CHIRP_MIN_CYC && dwell_q + 1 <= CHIRP_MAX_CYC
    ) else $error("chirp duration out of range");

    pair_count_a: assert property (
        state_q == ST_CHIRP_J && state_d == ST_SOF_WAIT |-> pairs_q == 2'(`CHIRP_PAIRS - 1)
    ) else $error("handshake ended with too few chirp pairs");

    first_sof_a: assert property (
        state_q == ST_SOF_WAIT && state_d == ST_RUN
        |-> dwell_q + 1 >= SOF1_MIN_CYC && dwell_q + 1 <= SOF1_MAX_CYC ##1 sof_out
    ) else $error("first frame marker outside its window");

    frame_period_a: assert property (
        sof_d && gap_ok_q |-> gap_q + 1 == (hs_q ? HS_FRAME_CYC : FS_FRAME_CYC)
    ) else $error("frame marker period wrong");

    no_sof_susp_a: assert property (
        state_q == ST_SUSPEND |=> !sof_out
    ) else $error("frame marker sent while suspended");

    resume_sof_a: assert property (
        res_q <= RESUME_MAX_CYC
    ) else $error("frame markers not restarted after resume");

    test_enter_a: assert property (
        test_q != TM_OFF |=> state_q == ST_TEST
    ) else $error("test mode not entered");

    test_se0_a: assert property (
        state_q == ST_TEST && test_q == TM_SE0_NAK |=> dp_oe_n_out && dm_oe_n_out && hs_mode_out
    ) else $error("test SE0 drives a line");

    test_j_a: assert property (
        state_q == ST_TEST && test_q == TM_J
        |=> dp_out && !dm_out && !dp_oe_n_out && !dm_oe_n_out
    ) else $error("test J line state wrong");

    test_k_a: assert property (
        state_q == ST_TEST && test_q == TM_K
        |=> !dp_out && dm_out && !dp_oe_n_out && !dm_oe_n_out
    ) else $error("test K line state wrong");

    nak_reply_a: assert property (
        in_token_in && state_q == ST_TEST && test_q == TM_SE0_NAK |=> nak_out
    ) else $error("IN token not answered with NAK");

    handshake_done_c: cover property (state_q == ST_CHIRP_J && state_d == ST_SOF_WAIT);
    resume_back_c: cover property (state_q == ST_RESUME && state_d == ST_RUN);
    test_nak_c: cover property (nak_out);
endmodule : usb_port_ctrl

/* verification/usb_dev_model.sv */
// attached device model: chirp K on request, full-speed J after suspend, pull-downs
module usb_dev_model #(
    parameter int SUSP_CYC = 1200
) (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic dp_in,
    input  wire logic dm_in,
    input  wire logic dp_oe_n_in,
    input  wire logic dm_oe_n_in,
    input  wire logic sof_in,
    input  wire logic chirp_in,
    output logic      dp_wire_out,
    output logic      dm_wire_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] idle_q;
    logic        armed_q;
    logic        fs_j;

    // time since the last frame marker; armed only once markers have run
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            idle_q  <= 16'h0000;
            armed_q <= 1'b0;
        end else if (sof_in) begin
            idle_q  <= 16'h0000;
            armed_q <= 1'b1;
        end else if (idle_q != 16'hffff) begin
            idle_q <= idle_q + 16'h0001;
        end
    end

    // pull-up back on after markers stop; released lines sit at SE0
    assign fs_j        = armed_q && (idle_q >= SUSP_CYC);
    assign dp_wire_out = !dp_oe_n_in ? dp_in : (chirp_in ? 1'b0 : fs_j);
    assign dm_wire_out = !dm_oe_n_in ? dm_in : chirp_in;
endmodule : usb_dev_model

/* verification/usb_port_ctrl_tb.sv */
// self-checking bench for the host port controller
module usb_port_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in, nrst_in, wr_in, rd_in, in_token_in, chirp;
    logic [3:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, rv;
    logic        dp_out, dm_out, dp_oe_n_out, dm_oe_n_out, hs_mode_out, sof_out, nak_out;
    logic        dp_w, dm_w;
    int          fail_count, checks_done, n, i;
    int          seed = 32'h375d;

    // shortened intervals, shared by the port and by the bench's expectations
    localparam int RESP_MAX = 40;
    localparam int CH_MIN   = 16;
    localparam int CH_MAX   = 24;
    localparam int S1_MIN   = 40;
    localparam int S1_MAX   = 200;
    localparam int HS_FR    = 50;
    localparam int FS_FR    = 400;
    localparam int RES_MAX  = 1200;

    usb_port_ctrl #(.RESP_MAX_CYC(RESP_MAX), .CHIRP_MIN_CYC(CH_MIN), .CHIRP_MAX_CYC(CH_MAX),
        .SOF1_MIN_CYC(S1_MIN), .SOF1_MAX_CYC(S1_MAX), .HS_FRAME_CYC(HS_FR),
        .FS_FRAME_CYC(FS_FR), .RESUME_MAX_CYC(RES_MAX)) u_usb_port_ctrl (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .dp_in(dp_w), .dm_in(dm_w), .dp_out(dp_out), .dm_out(dm_out),
        .dp_oe_n_out(dp_oe_n_out), .dm_oe_n_out(dm_oe_n_out), .hs_mode_out(hs_mode_out),
        .sof_out(sof_out), .in_token_in(in_token_in), .nak_out(nak_out));
    usb_dev_model u_usb_dev_model (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .dp_in(dp_out), .dm_in(dm_out), .dp_oe_n_in(dp_oe_n_out),
        .dm_oe_n_in(dm_oe_n_out), .sof_in(sof_out), .chirp_in(chirp),
        .dp_wire_out(dp_w), .dm_wire_out(dm_w));

    // 200 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("Error at %0t got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : chk_rng

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        @(negedge clk_sys_in);
        d = rdata_out;
    endtask : rd

    // line state the port drives: 0 released, 1 J, 2 K
    function automatic int line_st();
        if (dp_oe_n_out !== 1'b0 && dm_oe_n_out !== 1'b0) return 0;
        return (dp_out === 1'b1 && dm_out === 1'b0) ? 1 : 2;
    endfunction : line_st

    task automatic run_len(output int len, output int st);
        st  = line_st();
        len = 0;
        while (line_st() == st && len < 5000) begin
            @(negedge clk_sys_in);
            len++;
        end
    endtask : run_len

    // cycles to the next frame marker, capped at lim
    task automatic wait_sof(input int lim, output int len);
        len = 0;
        do begin
            @(negedge clk_sys_in);
            len++;
        end while (sof_out !== 1'b1 && len < lim);
    endtask : wait_sof

    initial begin
        repeat (60000) @(posedge clk_sys_in);
        fail_count++;
        finish_test();
    end

    initial begin
        int st, prev, k;
        {nrst_in, wr_in, rd_in, in_token_in, chirp} = 5'b00000;
        addr_in  = 4'h0;
        wdata_in = 32'h0000_0000;
        repeat (5) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        // reset values, unmapped write ignored and unmapped read zero
        wr(4'hc, $random(seed));
        rd(4'h0, rv); chk_val(rv, 32'h0000_0000);
        rd(4'h4, rv); chk_val(rv, 32'h0000_0001);
        rd(4'h8, rv); chk_val(rv, 32'h0000_0000);
        rd(4'hc, rv); chk_val(rv, 32'h0000_0000);
        chk_val({hs_mode_out, dp_oe_n_out, dm_oe_n_out, sof_out}, 32'h0000_0006);
        // high-speed handshake with a random device chirp length
        wr(4'h0, 32'h0000_0001);
        repeat (4) @(posedge clk_sys_in);
        k = 10 + ($unsigned($random(seed)) % 21);
        chirp <= 1'b1;
        repeat (k) @(posedge clk_sys_in);
        chirp <= 1'b0;
        @(negedge clk_sys_in);
        run_len(n, st);
        chk_rng(n, 1, RESP_MAX);
        prev = 1;
        for (i = 0; i < 6; i++) begin
            run_len(n, st);
            chk_val(st, (prev == 1) ? 2 : 1);
            chk_rng(n, CH_MIN, CH_MAX);
            prev = st;
        end
        wait_sof(400, n);
        chk_rng(n, S1_MIN, S1_MAX);
        for (i = 0; i < 3; i++) begin
            wait_sof(400, n);
            chk_val(n, HS_FR);
        end
        rd(4'h8, rv); chk_val(rv, 32'h0000_0004);
        rd(4'h4, rv); chk_val(rv, 32'h0007_0080);
        // suspend stops markers; resume as firmware must sequence it
        wr(4'h0, 32'h0000_0004);
        repeat (2) @(posedge clk_sys_in);
        wait_sof(1300, n);
        chk_val(n, 1300);
        wr(4'h0, 32'h0000_0008);
        repeat (3) @(negedge clk_sys_in);
        chk_val(line_st(), 2);
        repeat (8000) @(posedge clk_sys_in);
        wr(4'h0, 32'h0000_0000);
        wait_sof(1300, n);
        chk_rng(n, 1, RES_MAX);
        // each electrical test mode, the first entered from running, the other two from idle
        for (i = 1; i < 4; i++) begin
            wr(4'h0, i << 4);
            repeat (3) @(negedge clk_sys_in);
            if (i == 3) begin
                chk_val({hs_mode_out, dp_oe_n_out, dm_oe_n_out, dp_w, dm_w}, 32'h1c);
                k = 1 + ($unsigned($random(seed)) % 3);
                repeat (k) begin
                    @(posedge clk_sys_in);
                    in_token_in <= 1'b1;
                    @(posedge clk_sys_in);
                    in_token_in <= 1'b0;
                    @(negedge clk_sys_in);
                    chk_val(nak_out, 1'b1);
                    @(negedge clk_sys_in);
                    chk_val({nak_out, sof_out}, 2'b00);
                end
            end else begin
                chk_val({dp_oe_n_out, dm_oe_n_out, dp_w, dm_w}, (i == 1) ? 32'h2 : 32'h1);
                repeat (20) @(negedge clk_sys_in);
                chk_val(line_st(), i);
            end
            wr(4'h0, 32'h0000_0000);
            rd(4'h4, rv); chk_val(rv[10:0], 11'h001);
        end
        // full-speed start: a marker every frame
        wr(4'h0, 32'h0000_0003);
        wait_sof(600, n);
        chk_rng(n, S1_MIN, S1_MAX);
        for (i = 0; i < 2; i++) begin
            wait_sof(600, n);
            chk_val(n, FS_FR);
        end
        chk_val(hs_mode_out, 1'b0);
        finish_test();
    end
endmodule : usb_port_ctrl_tb
